// ---- core/cps_pkg.sv ----
`default_nettype none
package cps_pkg;
  // ***********************************************************
  // register map (byte addresses, one word per register)
  // ***********************************************************
  localparam logic [7:0] OFS_SENSE_FIRST  = 8'h00;
  localparam logic [7:0] OFS_SENSE_SECOND = 8'h04;
  localparam logic [7:0] OFS_TIMER_A_CTRL = 8'h08;
  localparam logic [7:0] OFS_TIMER_B_CTRL = 8'h0C;
  localparam logic [7:0] OFS_TIMER_B_GATE = 8'h10;
  localparam logic [7:0] OFS_TIMER_A_CNT  = 8'h14;
  localparam logic [7:0] OFS_TIMER_B_CNT  = 8'h18;
  localparam logic [7:0] OFS_NOISE_CTRL   = 8'h1C;

  // ***********************************************************
  // field positions
  // ***********************************************************
  localparam int unsigned BIT_ENABLE     = 7;
  localparam int unsigned RANGE_LSB      = 2;
  localparam int unsigned BIT_STATUS     = 1;
  localparam int unsigned BIT_EXT_SEL    = 0;
  localparam int unsigned CHAN_LSB       = 0;
  localparam int unsigned BIT_TA_SRC     = 0;
  localparam int unsigned BIT_TA_OVF     = 7;
  localparam int unsigned TB_SRC_LSB     = 6;
  localparam int unsigned BIT_TB_ON      = 0;
  localparam int unsigned BIT_TB_GATE_EN = 7;
  localparam int unsigned BIT_NOISE      = 0;

  // ***********************************************************
  // encodings, reset values, counts
  // ***********************************************************
  typedef enum logic [1:0] {
    RANGE_OFF  = 2'h0,
    RANGE_LOW  = 2'h1,
    RANGE_MED  = 2'h2,
    RANGE_HIGH = 2'h3
  } range_t;

  typedef enum logic [1:0] {
    TB_SRC_FOSC4 = 2'h0,
    TB_SRC_FOSC  = 2'h1,
    TB_SRC_NONE  = 2'h2,
    TB_SRC_OSC   = 2'h3
  } tb_src_t;

  localparam logic [1:0]  PRESCALE_LAST = 2'h3;
  localparam logic [3:0]  RST_CHANNEL   = 4'h0;
  localparam logic [7:0]  RST_TA_COUNT  = 8'h00;
  localparam logic [15:0] RST_TB_COUNT  = 16'h0000;
  localparam logic [31:0] RST_RDATA     = 32'h0000_0000;
endpackage : cps_pkg
`default_nettype wire

// ---- core/edge_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser per bit plus a third stage for edge detection;
// the first stage feeds only the second
module edge_sync #(
  parameter int unsigned WIDTH = 3
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] level,
  output var  logic [WIDTH-1:0] rise
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] last;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta  <= '0;
      level <= '0;
      last  <= '0;
    end else begin
      meta  <= async_in;
      level <= meta;
      last  <= level;
    end
  end

  assign rise = level & ~last;
endmodule : edge_sync
`default_nettype wire

// ---- core/capacitive_touch_freq_counter.sv ----
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module capacitive_touch_freq_counter (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        osc_in,
  input  wire logic        timer_a_clock_pin,
  input  wire logic        timer_b_gate_pin,
  input  wire logic        sleep_active,
  output var  logic [15:0] sense_pad_select,
  output var  logic        osc_active,
  output var  logic        osc_current_enable,
  output var  logic [1:0]  osc_range
);
  // ***********************************************************
  // helpers
  // ***********************************************************
  function automatic logic range_on(input logic [1:0] r);
    return r != cps_pkg::RANGE_OFF;
  endfunction : range_on

  function automatic logic [15:0] pad_decode(input logic [3:0] ch);
    return 16'h0001 << ch;
  endfunction : pad_decode

  function automatic logic reg_mapped(input logic [7:0] a);
    return a == cps_pkg::OFS_SENSE_FIRST || a == cps_pkg::OFS_SENSE_SECOND
        || a == cps_pkg::OFS_TIMER_A_CTRL || a == cps_pkg::OFS_TIMER_B_CTRL
        || a == cps_pkg::OFS_TIMER_B_GATE || a == cps_pkg::OFS_TIMER_A_CNT
        || a == cps_pkg::OFS_TIMER_B_CNT || a == cps_pkg::OFS_NOISE_CTRL;
  endfunction : reg_mapped

  logic        sense_module_enable;
  logic [1:0]  current_range_select;
  logic        timer_a_ext_clock_select;
  logic [3:0]  sense_channel_select;
  logic        timer_a_clock_source;
  logic        timer_a_overflow;
  logic [1:0]  timer_b_clock_source;
  logic        timer_b_on;
  logic        timer_b_gate_enable;
  logic        noise_detect;
  logic [7:0]  timer_a_count;
  logic [15:0] timer_b_count;
  logic [1:0]  prescale;
  logic [2:0]  sync_level;
  logic [2:0]  sync_rise;
  logic        osc_running;
  logic        osc_edge;
  logic        osc_direction_status;
  logic        fosc4_tick;
  logic        timer_a_tick;
  logic        timer_b_tick;
  logic        timer_b_run;
  logic        wr_en;
  logic        ta_wr;
  logic        tb_wr;
  logic [31:0] next_rdata;

  // ***********************************************************
  // oscillator input
  // ***********************************************************
  edge_sync #(.WIDTH(3)) u_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in ({timer_b_gate_pin, timer_a_clock_pin, osc_in}),
    .level    (sync_level),
    .rise     (sync_rise)
  );

  // a stopped oscillator passes no edge, whatever the pin does
  assign osc_running = sense_module_enable && range_on(current_range_select);
  assign osc_edge    = sync_rise[0] && osc_running;
  // comparator high means current flows out of the pin
  assign osc_direction_status = sync_level[0] && osc_running;

  // ***********************************************************
  // apb slave
  // ***********************************************************
  assign wr_en = psel && penable && pready && pwrite;
  assign ta_wr = wr_en && paddr == cps_pkg::OFS_TIMER_A_CNT;
  assign tb_wr = wr_en && paddr == cps_pkg::OFS_TIMER_B_CNT;

  always_comb begin
    next_rdata = '0;
    unique case (paddr)
      cps_pkg::OFS_SENSE_FIRST: begin
        next_rdata[cps_pkg::BIT_ENABLE]  = sense_module_enable;
        next_rdata[cps_pkg::RANGE_LSB+:2] = current_range_select;
        next_rdata[cps_pkg::BIT_STATUS]  = osc_direction_status;
        next_rdata[cps_pkg::BIT_EXT_SEL] = timer_a_ext_clock_select;
      end
      cps_pkg::OFS_SENSE_SECOND:
        next_rdata[cps_pkg::CHAN_LSB+:4] = sense_channel_select;
      cps_pkg::OFS_TIMER_A_CTRL: begin
        next_rdata[cps_pkg::BIT_TA_SRC] = timer_a_clock_source;
        next_rdata[cps_pkg::BIT_TA_OVF] = timer_a_overflow;
      end
      cps_pkg::OFS_TIMER_B_CTRL: begin
        next_rdata[cps_pkg::TB_SRC_LSB+:2] = timer_b_clock_source;
        next_rdata[cps_pkg::BIT_TB_ON]     = timer_b_on;
      end
      cps_pkg::OFS_TIMER_B_GATE:
        next_rdata[cps_pkg::BIT_TB_GATE_EN] = timer_b_gate_enable;
      cps_pkg::OFS_TIMER_A_CNT: next_rdata[7:0] = timer_a_count;
      cps_pkg::OFS_TIMER_B_CNT: next_rdata[15:0] = timer_b_count;
      cps_pkg::OFS_NOISE_CTRL:  next_rdata[cps_pkg::BIT_NOISE] = noise_detect;
      default:                  next_rdata = '0;
    endcase
  end

  // one wait-free access phase: ready rises in the cycle after setup
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= cps_pkg::RST_RDATA;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !reg_mapped(paddr);
      prdata  <= (psel && !penable && !pwrite) ? next_rdata : cps_pkg::RST_RDATA;
    end
  end

  // ***********************************************************
  // control registers
  // ***********************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sense_module_enable      <= 1'b0;
      current_range_select     <= cps_pkg::RANGE_OFF;
      timer_a_ext_clock_select <= 1'b0;
      sense_channel_select     <= cps_pkg::RST_CHANNEL;
      timer_a_clock_source     <= 1'b0;
      timer_b_clock_source     <= cps_pkg::TB_SRC_FOSC4;
      timer_b_on               <= 1'b0;
      timer_b_gate_enable      <= 1'b0;
      noise_detect             <= 1'b0;
    end else if (wr_en) begin
      unique case (paddr)
        cps_pkg::OFS_SENSE_FIRST: begin
          sense_module_enable      <= pwdata[cps_pkg::BIT_ENABLE];
          current_range_select     <= pwdata[cps_pkg::RANGE_LSB+:2];
          timer_a_ext_clock_select <= pwdata[cps_pkg::BIT_EXT_SEL];
        end
        cps_pkg::OFS_SENSE_SECOND:
          sense_channel_select <= pwdata[cps_pkg::CHAN_LSB+:4];
        cps_pkg::OFS_TIMER_A_CTRL:
          timer_a_clock_source <= pwdata[cps_pkg::BIT_TA_SRC];
        cps_pkg::OFS_TIMER_B_CTRL: begin
          timer_b_clock_source <= pwdata[cps_pkg::TB_SRC_LSB+:2];
          timer_b_on           <= pwdata[cps_pkg::BIT_TB_ON];
        end
        cps_pkg::OFS_TIMER_B_GATE:
          timer_b_gate_enable <= pwdata[cps_pkg::BIT_TB_GATE_EN];
        cps_pkg::OFS_NOISE_CTRL:
          noise_detect <= pwdata[cps_pkg::BIT_NOISE];
        default: ;
      endcase
    end
  end

  // ***********************************************************
  // analog-facing outputs
  // ***********************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sense_pad_select   <= '0;
      osc_active         <= 1'b0;
      osc_current_enable <= 1'b0;
      osc_range          <= cps_pkg::RANGE_OFF;
    end else begin
      // channel field is ignored while disabled
      sense_pad_select <= sense_module_enable ? pad_decode(sense_channel_select) : '0;
      osc_active       <= osc_running;
      // noise mode lives in high range only: comparator on, pin current off
      osc_current_enable <= osc_running && !(noise_detect
                            && current_range_select == cps_pkg::RANGE_HIGH);
      osc_range        <= current_range_select;
    end
  end

  // ***********************************************************
  // timer a
  // ***********************************************************
  assign fosc4_tick = prescale == cps_pkg::PRESCALE_LAST;
  // timer a has no sleep clock, so it cannot take counts while asleep
  assign timer_a_tick = !sleep_active && (timer_a_clock_source
                        ? (timer_a_ext_clock_select ? osc_edge : sync_rise[1])
                        : fosc4_tick);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prescale <= '0;
    end else begin
      prescale <= prescale + 2'h1;
    end
  end

  // software load wins over a count in the same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_a_count <= cps_pkg::RST_TA_COUNT;
    end else if (ta_wr) begin
      timer_a_count <= pwdata[7:0];
    end else if (timer_a_tick) begin
      timer_a_count <= timer_a_count + 8'h01;
    end
  end

  // overflow set beats a software clear in the same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_a_overflow <= 1'b0;
    end else if (timer_a_tick && !ta_wr && timer_a_count == 8'hFF) begin
      timer_a_overflow <= 1'b1;
    end else if (wr_en && paddr == cps_pkg::OFS_TIMER_A_CTRL) begin
      timer_a_overflow <= pwdata[cps_pkg::BIT_TA_OVF];
    end
  end

  // ***********************************************************
  // timer b
  // ***********************************************************
  assign timer_b_run = timer_b_on && (!timer_b_gate_enable || sync_level[2]);

  always_comb begin
    unique case (timer_b_clock_source)
      cps_pkg::TB_SRC_FOSC4: timer_b_tick = fosc4_tick;
      cps_pkg::TB_SRC_FOSC:  timer_b_tick = 1'b1;
      cps_pkg::TB_SRC_NONE:  timer_b_tick = 1'b0;
      cps_pkg::TB_SRC_OSC:   timer_b_tick = osc_edge;
    endcase
  end

  // timer b keeps counting in sleep; only the time base needs waking
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_b_count <= cps_pkg::RST_TB_COUNT;
    end else if (tb_wr) begin
      timer_b_count <= pwdata[15:0];
    end else if (timer_b_run && timer_b_tick) begin
      timer_b_count <= timer_b_count + 16'h0001;
    end
  end

  // ***********************************************************
  // checks
  // ***********************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence osc_to_b_s;
    timer_b_clock_source == cps_pkg::TB_SRC_OSC && timer_b_run && !tb_wr;
  endsequence

  sequence range_off_s;
    current_range_select == cps_pkg::RANGE_OFF && !tb_wr;
  endsequence

  pad_onehot_a: assert property (sense_module_enable |=>
    $onehot(sense_pad_select) && sense_pad_select == pad_decode($past(sense_channel_select)))
    else $error("pad select does not match channel");
  pad_idle_a: assert property (!sense_module_enable |=> sense_pad_select == 16'h0000)
    else $error("pad selected while disabled");
  status_off_a: assert property (!osc_running |-> !osc_direction_status)
    else $error("direction status set with oscillator stopped");
  range_decode_a: assert property (sense_module_enable
    |=> osc_active == ($past(current_range_select) != cps_pkg::RANGE_OFF))
    else $error("range decode wrong");
  noise_quiet_a: assert property (osc_running && noise_detect
    && current_range_select == cps_pkg::RANGE_HIGH |=> osc_active && !osc_current_enable)
    else $error("pin current on in noise mode");
  tb_osc_count_a: assert property (osc_to_b_s and osc_edge
    |=> timer_b_count == $past(timer_b_count) + 16'h0001)
    else $error("oscillator edge not counted on timer b");
  tb_off_a: assert property (!timer_b_on && !tb_wr |=> $stable(timer_b_count))
    else $error("timer b counts while off");
  tb_gate_a: assert property (timer_b_on && timer_b_gate_enable
    && !sync_level[2] && !tb_wr |=> $stable(timer_b_count))
    else $error("timer b counts with gate closed");
  ta_pin_a: assert property (timer_a_clock_source && !timer_a_ext_clock_select
    && sync_rise[1] && !sleep_active && !ta_wr |=> timer_a_count == $past(timer_a_count) + 8'h01)
    else $error("clock pin edge not counted on timer a");
  ta_sleep_a: assert property (sleep_active && !ta_wr |=> $stable(timer_a_count))
    else $error("timer a counts in sleep");
  edge_once_a: assert property (osc_edge |=> !osc_edge)
    else $error("one oscillator edge counted twice");
  osc_gate_a: assert property (range_off_s [*2] |=> $stable(timer_b_count)
    || $past(timer_b_clock_source) != cps_pkg::TB_SRC_OSC)
    else $error("timer b moved on a stopped oscillator");
endmodule : capacitive_touch_freq_counter
`default_nettype wire

// ---- verification/pad_osc_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ************************************
// sense pad with relaxation oscillator
// ************************************
module pad_osc_model (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        osc_active,
  input  wire logic        osc_current_enable,
  input  wire logic [15:0] sense_pad_select,
  input  wire logic        noise_on,
  input  wire logic        stall,
  input  wire logic        slow,
  output var  logic        osc_in,
  output var  int          rises
);
  logic [2:0] cnt;
  logic       run;
  logic [2:0] last;

  // no connected pad means no load to charge, so the comparator never trips
  assign run  = osc_active && (sense_pad_select != 16'h0000) && !stall;
  assign last = slow ? 3'h5 : 3'h2;

  // osc_in high while sourcing; stepped on clk so each level lasts three or more cycles
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt    <= 3'h0;
      osc_in <= 1'b0;
      rises  <= 0;
    end else if (run && (osc_current_enable || noise_on)) begin
      cnt <= (cnt == last) ? 3'h0 : cnt + 3'h1;
      if (cnt == last) begin
        osc_in <= ~osc_in;
        rises  <= rises + (osc_in ? 0 : 1);
      end
    end
  end
endmodule : pad_osc_model
`default_nettype wire

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk;
  logic        reset_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        osc_in;
  logic        pin_a;
  logic        gate_pin;
  logic        sleep;
  logic [15:0] pads;
  logic        osc_active;
  logic        cur_en;
  logic [1:0]  osc_range;
  logic        noise_on;
  logic        stall;
  logic        slow;
  logic        last_err;
  int          rises;
  int          errors;
  int          n_compared;
  int          cycles = 0;
  time         rel_t;

  capacitive_touch_freq_counter i_capacitive_touch_freq_counter (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_in(osc_in), .timer_a_clock_pin(pin_a), .timer_b_gate_pin(gate_pin),
    .sleep_active(sleep), .sense_pad_select(pads), .osc_active(osc_active),
    .osc_current_enable(cur_en), .osc_range(osc_range)
  );
  pad_osc_model i_pad_osc_model (
    .clk(clk), .reset_n(reset_n), .osc_active(osc_active), .osc_current_enable(cur_en),
    .sense_pad_select(pads), .noise_on(noise_on), .stall(stall), .slow(slow),
    .osc_in(osc_in), .rises(rises)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // runs take about 1300 cycles; anything far past that is a hang
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      wrap_up();
    end
  end

  // ************************************
  // bus and compare helpers
  // ************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // no local limit: only the bench timeout ends a wait
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    q        = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    apb(1'b0, a, 8'h00, q);
  endtask : rd

  task automatic settle();
    repeat (2) @(posedge clk);
  endtask : settle

  // the gate window here is a plain wait, not the counting timer; t_timebase uses timer a overflow
  task automatic run_osc(input int n);
    stall <= 1'b0;
    repeat (n) @(posedge clk);
    stall <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : run_osc

  task automatic measure(input logic [7:0] a, input logic runs, input logic live);
    int          r0;
    logic [31:0] q;
    wr(a, 8'h00);
    r0 = rises;
    run_osc(60);
    rd(a, q);
    check(q, runs ? 32'(rises - r0) : 32'h0000_0000);
    check(32'(rises != r0), 32'(live));
  endtask : measure

  // ************************************
  // scenarios
  // ************************************
  task automatic t_reset();
    logic [31:0] q;
    logic [31:0] want;
    for (int i = 0; i < 9; i++) begin
      // timer a runs on clk/4 from reset: one count per four edges since release
      want = (i == 5) ? 32'((($time - rel_t) / 10) / 4) : 32'h0000_0000;
      rd(8'(4 * i), q);
      check(q, want);
      check(32'(last_err), 32'(i == 8));
    end
    wr(8'h20, 8'hFF);
    check(32'(last_err), 32'h0000_0001);
    check(32'(pads), 32'h0000_0000);
  endtask : t_reset

  task automatic t_channels();
    wr(cps_pkg::OFS_SENSE_SECOND, 8'h05);
    settle();
    check(32'(pads), 32'h0000_0000);
    wr(cps_pkg::OFS_SENSE_FIRST, 8'h84);
    for (int ch = 0; ch < 16; ch++) begin
      wr(cps_pkg::OFS_SENSE_SECOND, 8'(ch));
      settle();
      check(32'(pads), 32'h0000_0001 << ch);
    end
  endtask : t_channels

  task automatic t_range();
    for (int r = 0; r < 4; r++) begin
      wr(cps_pkg::OFS_SENSE_FIRST, 8'(8'h80 | (r << 2)));
      settle();
      check(32'(osc_range), 32'(r));
      check(32'(osc_active), 32'(r != 0));
    end
    wr(cps_pkg::OFS_SENSE_FIRST, 8'h80);
    wr(cps_pkg::OFS_TIMER_B_CTRL, 8'hC1);
    measure(cps_pkg::OFS_TIMER_B_CNT, 1'b0, 1'b0);
  endtask : t_range

  task automatic t_timer_b();
    logic [2:0] cs [5] = '{3'b000, 3'b011, 3'b100, 3'b110, 3'b111};
    wr(cps_pkg::OFS_SENSE_FIRST, 8'h8C);
    for (int i = 0; i < 5; i++) begin
      gate_pin <= cs[i][0];
      wr(cps_pkg::OFS_TIMER_B_CTRL, {cps_pkg::TB_SRC_OSC, 5'h00, cs[i][2]});
      wr(cps_pkg::OFS_TIMER_B_GATE, {cs[i][1], 7'h00});
      measure(cps_pkg::OFS_TIMER_B_CNT, cs[i][2] & (~cs[i][1] | cs[i][0]), 1'b1);
    end
    slow <= 1'b1;
    measure(cps_pkg::OFS_TIMER_B_CNT, 1'b1, 1'b1);
    slow <= 1'b0;
    wr(cps_pkg::OFS_TIMER_B_CTRL, {cps_pkg::TB_SRC_NONE, 6'h01});
    measure(cps_pkg::OFS_TIMER_B_CNT, 1'b0, 1'b1);
  endtask : t_timer_b

  task automatic t_timer_a();
    logic [31:0] q;
    wr(cps_pkg::OFS_TIMER_B_CTRL, 8'h00);
    wr(cps_pkg::OFS_SENSE_FIRST, 8'h8D);
    wr(cps_pkg::OFS_TIMER_A_CTRL, 8'h01);
    measure(cps_pkg::OFS_TIMER_A_CNT, 1'b1, 1'b1);
    wr(cps_pkg::OFS_TIMER_A_CNT, 8'h00);
    sleep <= 1'b1;
    run_osc(60);
    sleep <= 1'b0;
    rd(cps_pkg::OFS_TIMER_A_CNT, q);
    check(q, 32'h0000_0000);
    check(32'(osc_active), 32'h0000_0001);
    wr(cps_pkg::OFS_SENSE_FIRST, 8'h8C);
    wr(cps_pkg::OFS_TIMER_A_CNT, 8'h00);
    stall <= 1'b0;
    repeat (5) begin
      pin_a <= 1'b1;
      repeat (3) @(posedge clk);
      pin_a <= 1'b0;
      repeat (3) @(posedge clk);
    end
    stall <= 1'b1;
    repeat (8) @(posedge clk);
    rd(cps_pkg::OFS_TIMER_A_CNT, q);
    check(q, 32'h0000_0005);
  endtask : t_timer_a

  task automatic t_noise();
    wr(cps_pkg::OFS_NOISE_CTRL, 8'h01);
    settle();
    check(32'(cur_en), 32'h0000_0000);
    check(32'(osc_active), 32'h0000_0001);
    wr(cps_pkg::OFS_TIMER_B_CTRL, 8'hC1);
    wr(cps_pkg::OFS_TIMER_B_GATE, 8'h00);
    measure(cps_pkg::OFS_TIMER_B_CNT, 1'b0, 1'b0);
    noise_on <= 1'b1;
    measure(cps_pkg::OFS_TIMER_B_CNT, 1'b1, 1'b1);
    noise_on <= 1'b0;
    wr(cps_pkg::OFS_SENSE_FIRST, 8'h84);
    settle();
    check(32'(cur_en), 32'h0000_0001);
    wr(cps_pkg::OFS_NOISE_CTRL, 8'h00);
  endtask : t_noise

  // timer a overflow closes the window; gate toggle mode is not built
  task automatic t_timebase();
    int          r0;
    logic [31:0] q;
    wr(cps_pkg::OFS_SENSE_FIRST, 8'h8C);
    wr(cps_pkg::OFS_TIMER_A_CTRL, 8'h00);
    wr(cps_pkg::OFS_TIMER_A_CNT, 8'hF0);
    wr(cps_pkg::OFS_TIMER_B_CTRL, 8'hC1);
    wr(cps_pkg::OFS_TIMER_B_CNT, 8'h00);
    r0    = rises;
    q     = 32'h0000_0000;
    stall <= 1'b0;
    while (q[cps_pkg::BIT_TA_OVF] !== 1'b1) begin
      rd(cps_pkg::OFS_TIMER_A_CTRL, q);
    end
    stall <= 1'b1;
    repeat (8) @(posedge clk);
    rd(cps_pkg::OFS_TIMER_B_CNT, q);
    check(q, 32'(rises - r0));
    wr(cps_pkg::OFS_TIMER_A_CTRL, 8'h00);
    rd(cps_pkg::OFS_TIMER_A_CTRL, q);
    check(q, 32'h0000_0000);
  endtask : t_timebase

  task automatic t_status();
    logic [31:0] q;
    wr(cps_pkg::OFS_SENSE_FIRST, 8'h8C);
    for (int i = 0; i < 2; i++) begin
      run_osc(3);
      rd(cps_pkg::OFS_SENSE_FIRST, q);
      check(32'(q[1]), 32'(osc_in));
    end
  endtask : t_status

  task automatic wrap_up();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  initial begin
    reset_n    = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 8'h00;
    pwdata     = 32'h0000_0000;
    pin_a      = 1'b0;
    gate_pin   = 1'b0;
    sleep      = 1'b0;
    noise_on   = 1'b0;
    stall      = 1'b1;
    slow       = 1'b0;
    errors     = 0;
    n_compared = 0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    rel_t = $time;
    @(posedge clk);
    t_reset();
    t_channels();
    t_range();
    t_timer_b();
    t_timer_a();
    t_noise();
    t_timebase();
    t_status();
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
